/* File: design/pin_mux_pkg.sv */
// Behaviour
// - after reset only test clock and reset pins take primary function
// - peripheral enable plus select picks alternates
// - test clock pin defaults to test role, pulled up
// - low reset pin resets and holds device
// - internal reset released synchronously after fixed count
// - repurposed reset pin no longer resets device
// - each port line individually input or output
// - port c and f pins default to port role
// - clock out pin carries selected clock source
// - serial transmit pin, shared line in single wire
package pin_mux_pkg;
  // number of multiplexed pins handled here
  localparam int unsigned NUM_PINS = 7;
  // pin indices
  localparam int unsigned PIN_TCK   = 0;
  localparam int unsigned PIN_RST   = 1;
  localparam int unsigned PIN_C0    = 2;
  localparam int unsigned PIN_C1    = 3;
  localparam int unsigned PIN_C2    = 4;
  localparam int unsigned PIN_F8    = 5;
  localparam int unsigned PIN_C3    = 6;
  // register offsets
  localparam logic [3:0] REG_PERIPH_EN  = 4'h0;
  localparam logic [3:0] REG_SEL_LO     = 4'h1;
  localparam logic [3:0] REG_SEL_HI     = 4'h2;
  localparam logic [3:0] REG_PORT_DIR   = 4'h3;
  localparam logic [3:0] REG_PORT_OUT   = 4'h4;
  localparam logic [3:0] REG_PORT_IN    = 4'h5;
  localparam logic [3:0] REG_CLOCK_OUTPUT_SELECT_REG_SEL = 4'h6;
  localparam logic [3:0] REG_CTRL       = 4'h7;
  localparam logic [3:0] REG_STATUS     = 4'h8;
  // reset values
  localparam logic [6:0] PERIPH_EN_RST = 7'h03;
  localparam logic [6:0] DIR_RST       = 7'h00;
  localparam logic [6:0] OUT_RST       = 7'h00;
  localparam logic [2:0] SEL_RST       = 3'h0;
  localparam logic [2:0] CLKSEL_RST    = 3'h0;
  // ctrl bit positions
  localparam int unsigned CTRL_SWRST = 0;
  localparam int unsigned CTRL_SWIRE = 1;
  // reset release delay in cycles
  localparam logic [4:0] RST_RELEASE_CYCLES = 5'h10;
  // alternate selector codes
  typedef enum logic [2:0]
  {
    ALT0 = 3'b000,
    ALT1 = 3'b001,
    ALT2 = 3'b010,
    ALT3 = 3'b011,
    ALT4 = 3'b100
  } alt_sel_t;
endpackage : pin_mux_pkg

/* File: design/reset_sync_if.sv */
// carries reset request and released internal reset
interface reset_sync_if;
  logic req;   // any reset source active
  logic rst;   // internal reset output
  modport ctrl (output req, input rst);
  modport gen  (input req, output rst);
endinterface : reset_sync_if

/* File: design/reset_release.sv */
// stretches reset and releases it after fixed count
module reset_release
  import pin_mux_pkg::*;
(
  // clock
  input  wire logic mclk_in,
  // reset link
  reset_sync_if.gen rs
);
  logic [4:0] count;  // cycles left until release

  // hold while requested, count down to release
  always_ff @(posedge mclk_in)
  begin
    if (rs.req)
    begin
      count  <= RST_RELEASE_CYCLES;
      rs.rst <= 1'b1;
    end
    else if (count != 5'h00)
    begin
      count  <= count - 5'h01;
      rs.rst <= 1'b1;
    end
    else
    begin
      rs.rst <= 1'b0;
    end
  end
endmodule : reset_release

/* File: design/pin_function_mux_reset_pins.sv */
// pin function multiplexer for the first seven pins
module pin_function_mux_reset_pins
  import pin_mux_pkg::*;
(
  // clock and power-on reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // other reset sources
  input  wire logic       watchdog_rst_in,
  // pads
  input  wire logic [6:0] pad_in,
  output logic      [6:0] pad_out,
  output logic      [6:0] pad_oe_out,
  output logic      [6:0] pad_pullup_out,
  // peripheral signals toward pins
  input  wire logic       test_clk_en_in,
  input  wire logic       serial0_tx_in,
  input  wire logic       serial0_tx_oe_in,
  input  wire logic       crossbar_out_11_in,
  input  wire logic       crossbar_out_10_in,
  input  wire logic       comparator_d_out_in,
  input  wire logic       comparator_a_out_in,
  input  wire logic       timer_a_ch0_in,
  input  wire logic [3:0] clock_sources_in,
  // peripheral signals from pins
  output logic            test_clock_out,
  output logic            serial0_rx_out,
  output logic            crossbar_in_2_out,
  output logic            ext_clock_in_0_out,
  output logic            ext_clock_in_1_out,
  output logic            timer_a_ch0_out,
  output logic            crystal_active_out,
  // internal reset
  output logic            sys_rst_out
);
  // reset path
  reset_sync_if rs ();                 // reset link
  logic             sw_rst_req;        // software reset pulse
  logic             pin_rst_req;       // reset pin asserted
  logic             last_rst_pin;      // reset source was pin

  // configuration registers
  logic       [6:0] periph_en;         // per pin peripheral enable
  logic       [6:0] port_dir;          // 1 means output
  logic       [6:0] port_out;          // port output data
  alt_sel_t         sel [NUM_PINS];    // per pin alternate select
  logic       [2:0] clock_out_source_select;  // clock out source
  logic             single_wire;       // serial single wire mode

  // pad synchroniser stages
  logic       [6:0] pad_meta;          // sync stage one
  logic       [6:0] pad_sync;          // sync stage two

  // pin output staging
  logic       [6:0] next_out;          // pin drive
  logic       [6:0] next_oe;           // pin enable
  logic             clk_sel_bit;       // chosen clock source

  // two-flop synchroniser for every pad
  always_ff @(posedge mclk_in)
  begin
    pad_meta <= pad_in;
    pad_sync <= pad_meta;
  end

  // reset pin counts only in its reset role
  assign pin_rst_req = ~periph_en[PIN_RST] ? 1'b0 : ~pad_sync[PIN_RST];
  assign rs.req = rst_in | watchdog_rst_in | sw_rst_req | pin_rst_req;

  reset_release u_release
  (
    .mclk_in (mclk_in),
    .rs      (rs)
  );

  // peripheral enables, port role on c and f after reset
  always_ff @(posedge mclk_in)
  begin
    if (rs.rst)
      periph_en <= PERIPH_EN_RST;
    else if (wr_in && addr_in == REG_PERIPH_EN)
      periph_en <= wdata_in[6:0];
  end

  // per pin select fields
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_sel
      // low register holds pins 0 and 1, high register the rest
      // field position fixed per pin, so no out of range slice
      localparam logic [3:0]  SEL_ADDR = (gi < 2) ? REG_SEL_LO : REG_SEL_HI;
      localparam int unsigned SEL_LSB  = (gi < 2) ? gi*4 : ((gi-2)%2)*4;
      always_ff @(posedge mclk_in)
      begin
        if (rs.rst)
          sel[gi] <= alt_sel_t'(SEL_RST);
        else if (wr_in && addr_in == SEL_ADDR)
          sel[gi] <= alt_sel_t'(wdata_in[SEL_LSB +: 3]);
      end
    end
  endgenerate

  // port direction and data
  always_ff @(posedge mclk_in)
  begin
    if (rs.rst)
    begin
      port_dir <= DIR_RST;
      port_out <= OUT_RST;
    end
    else if (wr_in && addr_in == REG_PORT_DIR)
      port_dir <= wdata_in[6:0];
    else if (wr_in && addr_in == REG_PORT_OUT)
      port_out <= wdata_in[6:0];
  end

  // clock out select and control bits
  always_ff @(posedge mclk_in)
  begin
    if (rs.rst)
    begin
      clock_out_source_select <= CLKSEL_RST;
      single_wire             <= 1'b0;
    end
    else if (wr_in && addr_in == REG_CLOCK_OUTPUT_SELECT_REG_SEL)
      clock_out_source_select <= wdata_in[2:0];
    else if (wr_in && addr_in == REG_CTRL)
      single_wire <= wdata_in[CTRL_SWIRE];
  end

  // software reset request pulse
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      sw_rst_req <= 1'b0;
    else
      sw_rst_req <= wr_in && addr_in == REG_CTRL && wdata_in[CTRL_SWRST];
  end

  // remember pin caused reset
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      last_rst_pin <= 1'b0;
    else if (pin_rst_req)
      last_rst_pin <= 1'b1;
    else if (rd_in && addr_in == REG_STATUS)
      last_rst_pin <= 1'b0;
  end

  // clock source mux
  assign clk_sel_bit = clock_sources_in[clock_out_source_select[1:0]];

  // one owner per pin output
  always_comb
  begin
    // start from port logic, peripherals override per pin
    next_out = port_out;
    next_oe  = port_dir;

    // test clock pin: input only in test role
    if (periph_en[PIN_TCK])
    begin
      next_out[PIN_TCK] = 1'b0;
      next_oe[PIN_TCK]  = 1'b0;
    end

    // reset pin: input only in reset role
    if (periph_en[PIN_RST])
    begin
      next_out[PIN_RST] = 1'b0;
      next_oe[PIN_RST]  = 1'b0;
    end

    // crystal and clock input pins are inputs
    if (periph_en[PIN_C0])
    begin
      next_out[PIN_C0] = 1'b0;
      next_oe[PIN_C0]  = 1'b0;
    end
    // crystal output pin left to the oscillator
    if (periph_en[PIN_C1])
    begin
      next_out[PIN_C1] = 1'b0;
      next_oe[PIN_C1]  = 1'b0;
    end
    // port c line 2 alternates
    if (periph_en[PIN_C2])
    begin
      unique case (sel[PIN_C2])
        ALT0:
        begin
          next_out[PIN_C2] = serial0_tx_in;
          next_oe[PIN_C2]  = single_wire ? serial0_tx_oe_in : 1'b1;
        end
        ALT1:
        begin
          next_out[PIN_C2] = crossbar_out_11_in;
          next_oe[PIN_C2]  = 1'b1;
        end
        ALT2:
        begin
          next_out[PIN_C2] = 1'b0;
          next_oe[PIN_C2]  = 1'b0;
        end
        default:
        begin
          next_out[PIN_C2] = clk_sel_bit;
          next_oe[PIN_C2]  = 1'b1;
        end
      endcase
    end
    // port f line 8 alternates
    if (periph_en[PIN_F8])
    begin
      unique case (sel[PIN_F8])
        ALT1:
        begin
          next_out[PIN_F8] = crossbar_out_10_in;
          next_oe[PIN_F8]  = 1'b1;
        end
        ALT2:
        begin
          next_out[PIN_F8] = comparator_d_out_in;
          next_oe[PIN_F8]  = 1'b1;
        end
        default:
        begin
          next_out[PIN_F8] = 1'b0;  // receive or aux input
          next_oe[PIN_F8]  = 1'b0;
        end
      endcase
    end
    // port c line 3 alternates
    if (periph_en[PIN_C3])
    begin
      unique case (sel[PIN_C3])
        ALT0:
        begin
          next_out[PIN_C3] = timer_a_ch0_in;
          next_oe[PIN_C3]  = 1'b1;
        end
        ALT1:
        begin
          next_out[PIN_C3] = comparator_a_out_in;
          next_oe[PIN_C3]  = 1'b1;
        end
        default:
        begin
          next_out[PIN_C3] = 1'b0;
          next_oe[PIN_C3]  = 1'b0;
        end
      endcase
    end
  end

  // registered pad drive and input routing
  always_ff @(posedge mclk_in)
  begin
    if (rs.rst)
    begin
      // pads released while in reset
      pad_out            <= 7'h00;
      pad_oe_out         <= 7'h00;
      pad_pullup_out     <= 7'h01;
      test_clock_out     <= 1'b1;
      serial0_rx_out     <= 1'b1;
      crossbar_in_2_out  <= 1'b0;
      ext_clock_in_0_out <= 1'b0;
      ext_clock_in_1_out <= 1'b0;
      timer_a_ch0_out    <= 1'b0;
      crystal_active_out <= 1'b0;
    end
    else
    begin
      // drive and enables follow staged values
      pad_out        <= next_out;
      pad_oe_out     <= next_oe;
      // pull-up only while test clock pin in test role
      pad_pullup_out <= {6'h00, periph_en[PIN_TCK]};
      test_clock_out <= periph_en[PIN_TCK] ? pad_sync[PIN_TCK] : 1'b1;
      // receive from single wire pin or dedicated rx pins
      if (periph_en[PIN_C2] && sel[PIN_C2] == ALT0 && single_wire)
        serial0_rx_out <= pad_sync[PIN_C2];
      else if (periph_en[PIN_F8] && sel[PIN_F8] == ALT0)
        serial0_rx_out <= pad_sync[PIN_F8];
      else if (periph_en[PIN_C3] && sel[PIN_C3] == ALT2)
        serial0_rx_out <= pad_sync[PIN_C3];
      else
        serial0_rx_out <= 1'b1;
      // routed peripheral inputs, idle low when unrouted
      crossbar_in_2_out  <= periph_en[PIN_C2] && sel[PIN_C2] == ALT2
                            && pad_sync[PIN_C2];
      ext_clock_in_0_out <= periph_en[PIN_C0] && sel[PIN_C0] == ALT1
                            && pad_sync[PIN_C0];
      ext_clock_in_1_out <= periph_en[PIN_C3] && sel[PIN_C3] == ALT3
                            && pad_sync[PIN_C3];
      timer_a_ch0_out    <= periph_en[PIN_C3] && sel[PIN_C3] == ALT0
                            && pad_sync[PIN_C3];
      crystal_active_out <= periph_en[PIN_C0] && sel[PIN_C0] == ALT0;
    end
  end

  // internal reset output
  always_ff @(posedge mclk_in)
  begin
    // extra stage keeps the output straight from a flip-flop
    sys_rst_out <= rs.rst;
  end

  // register read, data one cycle after strobe
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      unique case (addr_in)
        REG_PERIPH_EN:  rdata_out <= {1'b0, periph_en};
        REG_SEL_LO:     rdata_out <= {1'b0, sel[1], 1'b0, sel[0]};
        REG_SEL_HI:     rdata_out <= {1'b0, sel[3], 1'b0, sel[2]};
        REG_PORT_DIR:   rdata_out <= {1'b0, port_dir};
        REG_PORT_OUT:   rdata_out <= {1'b0, port_out};
        REG_PORT_IN:    rdata_out <= {1'b0, pad_sync};
        REG_CLOCK_OUTPUT_SELECT_REG_SEL: rdata_out <= {5'h00, clock_out_source_select};
        REG_CTRL:       rdata_out <= {6'h00, single_wire, 1'b0};
        REG_STATUS:     rdata_out <= {7'h00, last_rst_pin};
        default:        rdata_out <= 8'h00;
      endcase
    end
    else
      rdata_out <= 8'h00;
  end
endmodule : pin_function_mux_reset_pins

/* File: verification/pin_mux_assertions.sv */
// watches the pin mux top ports
module pin_mux_assertions
  import pin_mux_pkg::*;
(
  // clock, reset and register port
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] rdata_out,
  // reset sources and pads
  input  wire logic       watchdog_rst_in,
  input  wire logic [6:0] pad_oe_out,
  input  wire logic [6:0] pad_pullup_out,
  input  wire logic       test_clock_out,
  input  wire logic       sys_rst_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_reset_pads_off: assert property (
    sys_rst_out && $past(sys_rst_out) |-> pad_oe_out == 7'h00)
    else $error("pad driven during reset");
  a_tck_default_role: assert property (
    sys_rst_out && $past(sys_rst_out)
    |-> pad_pullup_out[PIN_TCK] && test_clock_out)
    else $error("test clock pin not pulled up in reset");
  a_rdata_idle_zero: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read answer");
  a_unmapped_reads: assert property (
    rd_in && addr_in > REG_STATUS |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_watchdog_enters: assert property (
    watchdog_rst_in |-> ##[1:4] sys_rst_out)
    else $error("watchdog did not reset");
  a_release_delay: assert property (
    $fell(watchdog_rst_in) |-> sys_rst_out [*8] ##[6:14] !sys_rst_out)
    else $error("reset release count wrong");
  a_swreset_enters: assert property (
    wr_in && addr_in == REG_CTRL && wdata_in[CTRL_SWRST] && !sys_rst_out
    |-> ##[1:4] sys_rst_out)
    else $error("software reset ignored");
  a_port_dir_drive: assert property (
    wr_in && addr_in == REG_PORT_DIR && !sys_rst_out
    && $past(wr_in && addr_in == REG_PERIPH_EN && wdata_in == 8'h00, 2)
    |-> ##2 pad_oe_out == $past(wdata_in[6:0], 2))
    else $error("port direction not on pads");
endmodule : pin_mux_assertions

bind pin_function_mux_reset_pins pin_mux_assertions chk_i (
  .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .watchdog_rst_in(watchdog_rst_in),
  .pad_oe_out(pad_oe_out), .pad_pullup_out(pad_pullup_out),
  .test_clock_out(test_clock_out), .sys_rst_out(sys_rst_out)
);

/* File: verification/testbench.sv */
// self-checking bench for the pin mux
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  logic       mclk_in, rst_in, wr_in, rd_in, watchdog_rst_in;
  logic [3:0] addr_in, clock_sources_in;
  logic [7:0] wdata_in, rdata_out, d;
  logic [7:0] per;  // peripheral drives toward pins
  logic [6:0] pad_in, pad_out, pad_oe_out, pad_pullup_out;
  logic       test_clock_out, serial0_rx_out, sys_rst_out;
  logic [4:0] routed;  // routed peripheral inputs from pins
  int         n_fail = 0, tests_run = 0, cycles = 0, n;
  pin_function_mux_reset_pins dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .watchdog_rst_in(watchdog_rst_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .pad_pullup_out(pad_pullup_out), .test_clk_en_in(per[0]),
    .serial0_tx_in(per[1]), .serial0_tx_oe_in(per[2]),
    .crossbar_out_11_in(per[3]), .crossbar_out_10_in(per[4]),
    .comparator_d_out_in(per[5]), .comparator_a_out_in(per[6]),
    .timer_a_ch0_in(per[7]), .clock_sources_in(clock_sources_in),
    .test_clock_out(test_clock_out), .serial0_rx_out(serial0_rx_out),
    .crossbar_in_2_out(routed[0]), .ext_clock_in_0_out(routed[1]),
    .ext_clock_in_1_out(routed[2]), .timer_a_ch0_out(routed[3]),
    .crystal_active_out(routed[4]), .sys_rst_out(sys_rst_out)
  );
  // 100 MHz clock
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // hang guard
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end
  // verdict and end of run
  task automatic stop_test;
    $display("fails %0d checks %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    if (got !== exp)
      n_fail = n_fail + 1;
  endtask : chk
  // wait cycles, then settle
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask : cyc
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= v;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  // one-cycle register read, data the cycle after
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  // bounded wait for internal reset release
  task automatic wait_rel(output int k);
    k = 0;
    while (sys_rst_out !== 1'b0 && k < 200)
    begin
      cyc(1);
      k = k + 1;
    end
  endtask : wait_rel
  // reset values and test clock role
  task automatic t_defaults;
    rd(REG_PERIPH_EN);
    chk(d, {1'b0, PERIPH_EN_RST});
    rd(REG_SEL_HI);
    chk(d, 8'h00);
    chk({1'b0, pad_oe_out}, 8'h00);
    chk({3'h0, routed}, 8'h00);
    chk({7'h0, pad_pullup_out[PIN_TCK]}, 8'h01);
    @(posedge mclk_in) pad_in <= 7'h7e;
    cyc(4);
    chk({7'h0, test_clock_out}, 8'h00);
    @(posedge mclk_in) pad_in <= 7'h7f;
    $display("done defaults");
  endtask : t_defaults
  // port mode directions, input levels, reset pin as port
  task automatic t_port;
    wr(REG_PERIPH_EN, 8'h00);
    wr(REG_PORT_DIR, 8'h55);
    wr(REG_PORT_OUT, 8'h7f);
    cyc(3);
    chk({1'b0, pad_oe_out}, 8'h55);
    chk({1'b0, pad_out} & 8'h55, 8'h55);
    @(posedge mclk_in) pad_in <= 7'h08;
    cyc(6);
    chk({7'h0, sys_rst_out}, 8'h00);
    rd(REG_PORT_IN);
    chk(d & 8'h2a, 8'h08);
    rd(4'hf);
    chk(d, 8'h00);
    @(posedge mclk_in) pad_in <= 7'h7f;
    $display("done port");
  endtask : t_port
  // alternate codes on pin c2, clock source choice
  task automatic t_clock_output_select_reg;
    wr(REG_PERIPH_EN, 8'h10);
    wr(REG_SEL_HI, 8'h01);
    @(posedge mclk_in) per[3] <= 1'b1;
    cyc(3);
    chk({7'h0, pad_out[PIN_C2]}, 8'h01);
    wr(REG_SEL_HI, 8'h02);
    cyc(3);
    chk({7'h0, routed[0]}, 8'h01);
    wr(REG_SEL_HI, 8'h03);
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_CLOCK_OUTPUT_SELECT_REG_SEL, 8'(k));
      @(posedge mclk_in) clock_sources_in <= 4'h1 << k;
      cyc(3);
      chk({7'h0, pad_out[PIN_C2]}, 8'h01);
      @(posedge mclk_in) clock_sources_in <= ~(4'h1 << k);
      cyc(3);
      chk({6'h0, pad_oe_out[PIN_C2], pad_out[PIN_C2]}, 8'h02);
    end
    $display("done clock out");
  endtask : t_clock_output_select_reg
  // serial transmit, then single-wire shared line
  task automatic t_serial;
    wr(REG_SEL_HI, 8'h00);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge mclk_in) per[1] <= v[0];
      cyc(3);
      chk({6'h0, pad_oe_out[PIN_C2], pad_out[PIN_C2]}, {7'h1, v[0]});
    end
    wr(REG_CTRL, 8'h02);
    @(posedge mclk_in) pad_in <= 7'h6f;
    cyc(5);
    chk({6'h0, pad_oe_out[PIN_C2], serial0_rx_out}, 8'h00);
    @(posedge mclk_in) pad_in <= 7'h7f;
    cyc(5);
    chk({7'h0, serial0_rx_out}, 8'h01);
    $display("done serial");
  endtask : t_serial
  // watchdog and software resets, release count
  task automatic t_resets;
    @(posedge mclk_in) watchdog_rst_in <= 1'b1;
    cyc(5);
    chk({7'h0, sys_rst_out}, 8'h01);
    @(posedge mclk_in) watchdog_rst_in <= 1'b0;
    wait_rel(n);
    chk({7'h0, n >= 16 && n <= 24}, 8'h01);
    rd(REG_PERIPH_EN);
    chk(d, {1'b0, PERIPH_EN_RST});
    wr(REG_CTRL, 8'h01);
    cyc(3);
    chk({7'h0, sys_rst_out}, 8'h01);
    wait_rel(n);
    rd(REG_CTRL);
    chk(d & 8'h02, 8'h00);
    $display("done resets");
  endtask : t_resets
  // reset pin low holds the device
  task automatic t_rstpin;
    @(posedge mclk_in) pad_in <= 7'h7d;
    cyc(40);
    chk({7'h0, sys_rst_out}, 8'h01);
    @(posedge mclk_in) pad_in <= 7'h7f;
    wait_rel(n);
    chk({7'h0, n >= 16}, 8'h01);
    rd(REG_STATUS);
    chk(d & 8'h01, 8'h01);
    rd(REG_STATUS);
    chk(d & 8'h01, 8'h00);
    $display("done reset pin");
  endtask : t_rstpin
  // main sequence
  initial
  begin
    {rst_in, wr_in, rd_in, watchdog_rst_in} = 4'h8;
    {addr_in, wdata_in, clock_sources_in, per} = 24'h0;
    pad_in = 7'h7f;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    cyc(1);
    wait_rel(n);
    t_defaults();
    t_port();
    t_clock_output_select_reg();
    t_serial();
    t_resets();
    t_rstpin();
    stop_test();
  end
endmodule : testbench
